// ==== inc/pcef_pkg.sv ====
// package: offsets, field positions, modes and timing for the channel event flag bank
package pcef_pkg;
  localparam int PCEF_NCH = 4;
  localparam logic [7:0] PCEF_OFF_PWR_RO = 8'h02;
  localparam logic [7:0] PCEF_OFF_PWR_RC = 8'h03;
  localparam logic [7:0] PCEF_OFF_DISC_RO = 8'h04;
  localparam logic [7:0] PCEF_OFF_DISC_RC = 8'h05;
  localparam logic [7:0] PCEF_OFF_FLT_RO = 8'h06;
  localparam logic [7:0] PCEF_OFF_FLT_RC = 8'h07;
  // own control registers
  localparam logic [7:0] PCEF_OFF_CTRL = 8'h40;
  localparam logic [7:0] PCEF_OFF_MASK = 8'h41;
  localparam logic [7:0] PCEF_OFF_PAIRCFG = 8'h42;
  localparam logic [7:0] PCEF_OFF_SUMMARY = 8'h43;
  // control register bit positions
  localparam int PCEF_CTRL_IRQ_EN = 0;
  localparam int PCEF_CTRL_CLS_SEL = 1;
  localparam int PCEF_CTRL_DET_SEL = 2;
  localparam int PCEF_CTRL_MODE_LO = 3;
  // pair config: bit0 pair12 4-pair, bit1 pair34 4-pair, bit2 pair12 dual sig, bit3 pair34 dual
  localparam int PCEF_PCFG_4P_LO = 0;
  localparam int PCEF_PCFG_DS_LO = 2;
  // summary bit positions, matching the mask register
  localparam int PCEF_SUM_PEC = 0;
  localparam int PCEF_SUM_PGC = 1;
  localparam int PCEF_SUM_DIS = 2;
  localparam int PCEF_SUM_DET = 3;
  localparam int PCEF_SUM_CLS = 4;
  localparam int PCEF_SUM_OVL = 5;
  localparam logic [7:0] PCEF_RST_BYTE = 8'h00;
  localparam logic [7:0] PCEF_MASK_RST = 8'h00;
  // operating modes
  typedef enum logic [1:0] {PCEF_MODE_MANUAL, PCEF_MODE_SEMI, PCEF_MODE_AUTO} pcef_mode_t;
  // pairing delay bound
  localparam int PCEF_CLK_HZ = 25000000;
  localparam int PCEF_PAIR_MS = 5;
  localparam int PCEF_PAIR_CYC = PCEF_CLK_HZ / 1000 * PCEF_PAIR_MS;
endpackage

// ==== verilog/pcef_pair_merge.sv ====
// pairing logic for one 4-pair port: holds per-channel events until both channels report
module pcef_pair_merge
  import pcef_pkg::*;
#(
  parameter int WAIT_CYC = PCEF_PAIR_CYC
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic hold_en, // combine the two channels
  input wire logic [1:0] ev_in, // per-channel event pulses
  input wire logic [1:0] ch_off, // channel turned off drops pending
  output logic [1:0] ev_out // released event pulses
);
  // a zero bound would drop every half pair before its partner could arrive
  if (WAIT_CYC < 1) begin : g_bad_wait
    $error("pcef_pair_merge: WAIT_CYC must be at least 1");
  end
  logic [1:0] pend_r;
  logic [1:0] pend_nxt;
  logic [31:0] age_r;
  logic both;
  logic timeout;
  // pending fills as each channel completes, release once both are in
  assign pend_nxt = (pend_r | ev_in) & ~ch_off;
  assign both = &pend_nxt;
  // a stray half result is dropped after the bound so it cannot stall
  assign timeout = (age_r >= 32'(WAIT_CYC)) && |pend_r;
  assign ev_out = hold_en ? (both ? 2'b11 : 2'b00) : ev_in;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !hold_en || both || timeout) begin
      pend_r <= 2'b00;
      age_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      age_r <= |pend_nxt ? age_r + 32'd1 : '0;
    end
  end
endmodule

// ==== verilog/pcef_event_bank.sv ====
// event flag registers for four channels: power change, discovery, fault; plain and clearing reads
// Notes on behaviour
// R01 - power change flags read at 02h plainly and at 03h with clear
// R02 - discovery flags read at 04h plainly and at 05h with clear
// R03 - fault flags read at 06h plainly and at 07h with clear
// R04 - clearing read returns contents then zeroes the register; plain read keeps it
// R05 - clearing read releases the interrupt when that register held it
// R06 - any set flag feeds its summary bit; flags active high and latching
// R07 - power change: bits 7-4 power-good change, bits 3-0 power-enable change
// R08 - discovery and fault flags of a channel clear when it turns off
// R09 - class flags set per cycle, or only on class change when selected
// R10 - detect flags set per cycle, or only on result change when selected
// R11 - fault: bits 7-4 disconnect, bits 3-0 overload timeout
// R12 - 4-pair enable-change, disconnect and overload flags update per channel
// R13 - 4-pair single signature: power-good change set once both channels changed
// R14 - 4-pair dual signature: enable and good changes set per channel
// R15 - 4-pair without power-on request: discovery flags wait for both channels
// R16 - in that case both detect flags set together within 5 ms
// R17 - single signature: only the classified pair set gets its class flag
// R18 - dual signature semi-auto: class flags together; manual: each alone
// R19 - dual signature with power-on request or auto: discovery flags per channel
// R20 - single signature disconnect sets both flags; dual sets each alone
// R21 - overload cutoff disabled: no turn-off, flag still set after timeout
// R22 - clearing overload flag leaves limit and overload counters untouched
// R23 - interrupt needs mask bit and global enable; flags update regardless
// R24 - event in the same cycle as a clearing read stays set
//
// The implementer's own choice: the address-and-strobe port.
module pcef_event_bank
  import pcef_pkg::*;
#(
  parameter int PAIR_WAIT_CYC = PCEF_PAIR_CYC
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  input wire logic [3:0] pg_status, // power-good status per channel, async
  input wire logic [3:0] pe_status, // power-enable status per channel, async
  input wire logic [3:0] det_done, // detection cycle completed pulse, async
  input wire logic [3:0] det_changed, // detection result differs from before
  input wire logic [3:0] cls_done, // classification completed pulse, async
  input wire logic [3:0] cls_changed, // measured class differs from before
  input wire logic [3:0] cls_primary, // this channel is the classified pair set
  input wire logic [3:0] disc_event, // disconnect detected pulse, async
  input wire logic [3:0] ovld_expired, // overload_timeout expired pulse, async
  input wire logic [3:0] power_on_request, // pending power-on request per channel
  input wire logic [3:0] overload_cut_en, // overload cutoff enabled per channel
  output logic [3:0] overload_turn_off, // request channel off after overload
  output logic irq_n // interrupt output, active low
);
  // refuse a pairing bound that would drop a half pair before its partner could arrive
  if (PAIR_WAIT_CYC < 1) begin : g_bad_wait
    $error("pcef_event_bank: PAIR_WAIT_CYC must be at least 1");
  end
  // latched event flags, the three software-visible event registers
  logic [7:0] pwr_r; // power change flags
  logic [7:0] disc_r; // discovery flags
  logic [7:0] flt_r; // fault flags
  // own control registers
  logic [7:0] ctrl_r; // enable, change selects, mode
  logic [7:0] mask_r; // per-summary interrupt mask
  logic [7:0] pcfg_r; // 4-pair and dual signature per pair
  // next values of the flag registers
  logic [7:0] pwr_nxt; // power change next
  logic [7:0] disc_nxt; // discovery next
  logic [7:0] flt_nxt; // fault next
  logic [7:0] rdata_r;
  logic irq_n_r;
  logic [3:0] off_r;
  // two-flop synchronisers for the status and event pin inputs; cls_primary and overload_cut_en are used directly
  logic [35:0] s1_r, s2_r;
  logic [35:0] pin_in;
  assign pin_in = {pg_status, pe_status, det_done, det_changed, cls_done, cls_changed,
                   disc_event, ovld_expired, power_on_request};
  always_ff @(posedge core_clk) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
  end
  logic [3:0] pg_s, pe_s, dd_s, dc_s, cd_s, cc_s, di_s, ov_s, por_s;
  assign {pg_s, pe_s, dd_s, dc_s, cd_s, cc_s, di_s, ov_s, por_s} = s2_r;
  // edge detection on status levels; these track the pins through reset as well,
  // so a pin that already stands high at release gives no false edge
  logic [3:0] pg_d_r, pe_d_r, dd_d_r, cd_d_r, di_d_r, ov_d_r;
  always_ff @(posedge core_clk) begin
    pg_d_r <= pg_s;
    pe_d_r <= pe_s;
    dd_d_r <= dd_s;
    cd_d_r <= cd_s;
    di_d_r <= di_s;
    ov_d_r <= ov_s;
  end
  // completion inputs count on their rising edge only, so a held level sets a flag once
  function automatic logic [3:0] rise4(input logic [3:0] now, input logic [3:0] was);
    return now & ~was;
  endfunction
  // status levels count on either edge
  function automatic logic [3:0] flip4(input logic [3:0] now, input logic [3:0] was);
    return now ^ was;
  endfunction
  logic [3:0] pg_chg, pe_chg, det_p, cls_p, dis_p, ovl_p, ch_off;
  assign pg_chg = flip4(pg_s, pg_d_r);
  assign pe_chg = flip4(pe_s, pe_d_r);
  assign det_p = rise4(dd_s, dd_d_r);
  assign cls_p = rise4(cd_s, cd_d_r);
  assign dis_p = rise4(di_s, di_d_r);
  assign ovl_p = rise4(ov_s, ov_d_r);
  // channel turned off: power-enable falls
  assign ch_off = pe_d_r & ~pe_s;
  // control fields
  logic cls_sel, det_sel, irq_en;
  pcef_mode_t mode;
  assign irq_en = ctrl_r[PCEF_CTRL_IRQ_EN];
  assign cls_sel = ctrl_r[PCEF_CTRL_CLS_SEL];
  assign det_sel = ctrl_r[PCEF_CTRL_DET_SEL];
  assign mode = pcef_mode_t'(ctrl_r[PCEF_CTRL_MODE_LO +: 2]);
  // qualified discovery events
  logic [3:0] det_q, cls_q;
  assign det_q = det_p & (det_sel ? dc_s : 4'hf); // R10
  assign cls_q = cls_p & (cls_sel ? cc_s : 4'hf); // R09
  // per-pair shaping
  logic [3:0] pgc_set, det_set, cls_set, dis_set;
  logic [1:0] four_p, dual;
  assign four_p = pcfg_r[PCEF_PCFG_4P_LO +: 2];
  assign dual = pcfg_r[PCEF_PCFG_DS_LO +: 2];
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      logic fp, ds, no_req, det_hold, cls_hold, pg_hold;
      logic [1:0] det_m, cls_m, pg_m;
      assign fp = four_p[p];
      assign ds = dual[p];
      assign no_req = ~|por_s[2*p +: 2] && mode != PCEF_MODE_AUTO;
      // detect flags wait for both channels when no power-on is pending and the mode is not auto
      assign det_hold = fp && no_req; // R15 R19
      // single sig: one class pair; dual semi-auto: together; manual: alone
      assign cls_hold = fp && no_req && ds && mode == PCEF_MODE_SEMI; // R18 R19
      // single signature power-good waits for both channels
      assign pg_hold = fp && !ds; // R13 R14
      pcef_pair_merge #(.WAIT_CYC(PAIR_WAIT_CYC)) u_det (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold_en(det_hold),
        .ev_in(det_q[2*p +: 2]),
        .ch_off(ch_off[2*p +: 2]),
        .ev_out(det_m)
      ); // R16
      pcef_pair_merge #(.WAIT_CYC(PAIR_WAIT_CYC)) u_cls (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold_en(cls_hold),
        .ev_in(cls_q[2*p +: 2]),
        .ch_off(ch_off[2*p +: 2]),
        .ev_out(cls_m)
      ); // R18
      pcef_pair_merge #(.WAIT_CYC(PAIR_WAIT_CYC)) u_pg (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .hold_en(pg_hold),
        .ev_in(pg_chg[2*p +: 2]),
        .ch_off(2'b00),
        .ev_out(pg_m)
      ); // R13
      assign det_set[2*p +: 2] = det_m;
      // single signature: only classified pair set flags
      assign cls_set[2*p +: 2] = (fp && !ds) ? (cls_m & cls_primary[2*p +: 2]) : cls_m; // R17
      assign pgc_set[2*p +: 2] = pg_m;
      // single signature disconnect marks both channels
      assign dis_set[2*p +: 2] = (fp && !ds && |dis_p[2*p +: 2]) ? 2'b11
                                 : dis_p[2*p +: 2]; // R20 R12
    end
  endgenerate
  // bus decode
  logic rd_pwr_clr, rd_disc_clr, rd_flt_clr;
  assign rd_pwr_clr = reg_rd && reg_addr == PCEF_OFF_PWR_RC; // R01
  assign rd_disc_clr = reg_rd && reg_addr == PCEF_OFF_DISC_RC; // R02
  assign rd_flt_clr = reg_rd && reg_addr == PCEF_OFF_FLT_RC; // R03
  // flag next values: clear, then channel-off for discovery and fault, then new events win
  assign pwr_nxt = (rd_pwr_clr ? PCEF_RST_BYTE : pwr_r) | {pgc_set, pe_chg}; // R04 R07 R12 R24
  assign disc_nxt = ((rd_disc_clr ? PCEF_RST_BYTE : disc_r) & ~{ch_off, ch_off})
                    | {cls_set, det_set}; // R04 R08 R24
  assign flt_nxt = ((rd_flt_clr ? PCEF_RST_BYTE : flt_r) & ~{ch_off, ch_off})
                   | {dis_set, ovl_p}; // R04 R08 R11 R12 R24
  // overload turns a channel off only when cutoff enabled; the overload and limit
  // timers live outside and never see the flag clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      off_r <= 4'h0;
    end else begin
      off_r <= ovl_p & overload_cut_en; // R21 R22
    end
  end
  assign overload_turn_off = off_r;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwr_r <= PCEF_RST_BYTE;
      disc_r <= PCEF_RST_BYTE;
      flt_r <= PCEF_RST_BYTE;
    end else begin
      pwr_r <= pwr_nxt;
      disc_r <= disc_nxt;
      flt_r <= flt_nxt;
    end
  end
  // control register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r <= PCEF_RST_BYTE;
      mask_r <= PCEF_MASK_RST;
      pcfg_r <= PCEF_RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == PCEF_OFF_CTRL) ctrl_r <= reg_wdata;
      else if (reg_addr == PCEF_OFF_MASK) mask_r <= reg_wdata;
      else if (reg_addr == PCEF_OFF_PAIRCFG) pcfg_r <= reg_wdata;
    end
  end
  // summary of set flags per event type
  // unused summary bits stay zero; the bit order matches the mask register
  logic [7:0] summary;
  always_comb begin
    summary = PCEF_RST_BYTE;
    summary[PCEF_SUM_PEC] = |pwr_r[3:0]; // R06
    summary[PCEF_SUM_PGC] = |pwr_r[7:4]; // R06
    summary[PCEF_SUM_DIS] = |flt_r[7:4]; // R06
    summary[PCEF_SUM_DET] = |disc_r[3:0]; // R06
    summary[PCEF_SUM_CLS] = |disc_r[7:4]; // R06
    summary[PCEF_SUM_OVL] = |flt_r[3:0]; // R06
  end
  // an event register answers at its plain code and at the clearing code
  function automatic logic at_pair(input logic [7:0] a, input logic [7:0] ro,
                                   input logic [7:0] rc);
    return (a == ro) || (a == rc);
  endfunction
  // read mux; unmapped reads return zero so a probe never sees stale data
  logic [7:0] rd_mux;
  always_comb begin
    if (at_pair(reg_addr, PCEF_OFF_PWR_RO, PCEF_OFF_PWR_RC)) rd_mux = pwr_r;
    else if (at_pair(reg_addr, PCEF_OFF_DISC_RO, PCEF_OFF_DISC_RC)) rd_mux = disc_r;
    else if (at_pair(reg_addr, PCEF_OFF_FLT_RO, PCEF_OFF_FLT_RC)) rd_mux = flt_r;
    else if (reg_addr == PCEF_OFF_CTRL) rd_mux = ctrl_r;
    else if (reg_addr == PCEF_OFF_MASK) rd_mux = mask_r;
    else if (reg_addr == PCEF_OFF_PAIRCFG) rd_mux = pcfg_r;
    else if (reg_addr == PCEF_OFF_SUMMARY) rd_mux = summary;
    else rd_mux = PCEF_RST_BYTE;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= PCEF_RST_BYTE;
    end else begin
      rdata_r <= reg_rd ? rd_mux : PCEF_RST_BYTE; // R04
    end
  end
  assign reg_rdata = rdata_r;
  // interrupt follows flags registered, so a clearing read releases it next edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~(irq_en && |(summary & mask_r)); // R05 R23
    end
  end
  assign irq_n = irq_n_r;
endmodule

// ==== bench/pcef_event_bank_monitor.sv ====
// checker for the port behaviour of the channel event flag bank
module pcef_event_bank_monitor
  import pcef_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [3:0] ovld_expired, // overload timeout pulses
  input wire logic [3:0] overload_cut_en, // cutoff enable per channel
  input wire logic [3:0] overload_turn_off, // turn-off request pulses
  input wire logic irq_n // interrupt, active low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_r;
  logic mz_r;
  logic [1:0] off_r;
  wire logic known;
  wire logic gate_off;
  // mapped codes: event registers and the control block
  assign known = (reg_addr >= PCEF_OFF_PWR_RO && reg_addr <= PCEF_OFF_FLT_RC)
    || (reg_addr >= PCEF_OFF_CTRL && reg_addr <= PCEF_OFF_SUMMARY);
  assign gate_off = !en_r || mz_r;
  // shadow of enable and mask; irq_n is registered, so the gate must stay shut two cycles
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      en_r <= 1'b0;
      mz_r <= 1'b1;
      off_r <= 2'b11;
    end else begin
      if (reg_wr && reg_addr == PCEF_OFF_CTRL) en_r <= reg_wdata[PCEF_CTRL_IRQ_EN];
      if (reg_wr && reg_addr == PCEF_OFF_MASK) mz_r <= (reg_wdata[5:0] == 6'h00);
      off_r <= {off_r[0], gate_off};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence ovl0_s;
    $rose(ovld_expired[0]) && overload_cut_en[0];
  endsequence
  sequence mask_wr_rd_s;
    reg_wr && reg_addr == PCEF_OFF_MASK ##2 reg_rd && reg_addr == PCEF_OFF_MASK;
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
    reg_rdata == 8'h00 && irq_n && overload_turn_off == 4'h0) else $error("reset outputs");
  irq_gate_a: assert property (off_r == 2'b11 && gate_off |-> irq_n)
    else $error("interrupt while gated");
  unmapped_zero_a: assert property (reg_rd && !known |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  mask_back_a: assert property (mask_wr_rd_s |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 3))
    else $error("mask readback");
  cut_cause_a: assert property (ovl0_s |-> ##[2:5] overload_turn_off[0])
    else $error("no turn-off after overload");
  cut_gate_a: assert property ((overload_turn_off & ~overload_cut_en) == 4'h0)
    else $error("turn-off with cutoff disabled");
  cut_pulse_a: assert property ((overload_turn_off & $past(overload_turn_off)) == 4'h0)
    else $error("turn-off longer than one cycle");
endmodule
bind pcef_event_bank pcef_event_bank_monitor u_pcef_event_bank_monitor(
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ovld_expired(ovld_expired),
  .overload_cut_en(overload_cut_en), .overload_turn_off(overload_turn_off), .irq_n(irq_n));

// ==== bench/pcef_host_model.sv ====
// host model: drives the register port with one-cycle strobes
module pcef_host_model (
  input wire logic core_clk, // core clock
  output logic [7:0] reg_addr, // register address
  output logic [7:0] reg_wdata, // write data
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  // strobes rest low until a task runs
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, so it is taken just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// ==== bench/pcef_event_bank_test.sv ====
// testbench: register sequences against the channel event flag bank
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module pcef_event_bank_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pcef_pkg::*;
  localparam int WAIT_CYC = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic [7:0] reg_addr;
  wire logic [7:0] reg_wdata;
  wire logic [7:0] reg_rdata;
  wire logic reg_wr;
  wire logic reg_rd;
  wire logic [3:0] overload_turn_off;
  wire logic irq_n;
  logic [3:0] pg_status = 4'h0;
  logic [3:0] pe_status = 4'h0;
  logic [3:0] det_changed = 4'h0;
  logic [3:0] cls_changed = 4'h0;
  logic [3:0] cls_primary = 4'h0;
  logic [3:0] pwr_req = 4'h0;
  logic [15:0] ev_r = 16'h0000;
  logic [7:0] codes [8] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h43, 8'h10};
  int error_cnt = 0;
  int checked = 0;
  always #20 core_clk = ~core_clk;
  pcef_host_model u_pcef_host_model(.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pcef_event_bank #(.PAIR_WAIT_CYC(WAIT_CYC)) u_pcef_event_bank(.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pg_status(pg_status), .pe_status(pe_status),
    .det_done(ev_r[3:0]), .det_changed(det_changed), .cls_done(ev_r[7:4]),
    .cls_changed(cls_changed), .cls_primary(cls_primary), .disc_event(ev_r[11:8]),
    .ovld_expired(ev_r[15:12]), .power_on_request(pwr_req), .overload_cut_en(4'h1),
    .overload_turn_off(overload_turn_off), .irq_n(irq_n));
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_pcef_host_model.rd(a, d);
    `CHK(d, e)
  endtask
  // event pulse: s picks detect, class, disconnect, overload; c picks the channel
  task automatic pls(input int s, input int c);
    @(posedge core_clk);
    ev_r[s * 4 + c] <= 1'b1;
    @(posedge core_clk);
    ev_r <= 16'h0000;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic st(input logic [3:0] pg, input logic [3:0] pe);
    @(posedge core_clk);
    pg_status <= pg;
    pe_status <= pe;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(40 * 5000);
    error_cnt++;
    print_verdict;
  end
  // main sequence; each block leaves flags clear for the next
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rc(codes[i], 8'h00);
    u_pcef_host_model.wr(8'h02, 8'hff);
    rc(8'h02, 8'h00);
    $display("reset test done");
    st(4'h0, 4'h1);
    rc(8'h02, 8'h01);
    rc(8'h02, 8'h01);
    rc(8'h03, 8'h01);
    rc(8'h02, 8'h00);
    st(4'h2, 4'h1);
    rc(8'h03, 8'h20);
    $display("power test done");
    pls(0, 2);
    rc(8'h05, 8'h04);
    pls(1, 3);
    rc(8'h05, 8'h80);
    u_pcef_host_model.wr(PCEF_OFF_CTRL, 8'h06);
    pls(1, 0);
    pls(0, 1);
    rc(8'h04, 8'h00);
    det_changed <= 4'h2;
    pls(0, 1);
    rc(8'h05, 8'h02);
    cls_changed <= 4'h1;
    pls(1, 0);
    rc(8'h05, 8'h10);
    u_pcef_host_model.wr(PCEF_OFF_CTRL, 8'h00);
    $display("discovery test done");
    pls(3, 1);
    rc(8'h06, 8'h02);
    pls(3, 0);
    rc(8'h07, 8'h03);
    pls(2, 3);
    rc(8'h07, 8'h80);
    pls(2, 0);
    pls(0, 0);
    st(4'h2, 4'h0);
    rc(8'h04, 8'h00);
    rc(8'h06, 8'h00);
    rc(8'h03, 8'h01);
    $display("fault test done");
    u_pcef_host_model.wr(PCEF_OFF_MASK, 8'h04);
    u_pcef_host_model.wr(PCEF_OFF_CTRL, 8'h01);
    pls(2, 1);
    `CHK(irq_n, 1'b0)
    rc(8'h07, 8'h20);
    repeat (2) @(posedge core_clk);
    #1 `CHK(irq_n, 1'b1)
    u_pcef_host_model.wr(PCEF_OFF_MASK, 8'h00);
    rc(PCEF_OFF_MASK, 8'h00);
    pls(2, 2);
    `CHK(irq_n, 1'b1)
    rc(8'h07, 8'h40);
    $display("interrupt test done");
    u_pcef_host_model.wr(PCEF_OFF_PAIRCFG, 8'h01);
    st(4'h3, 4'h0);
    rc(8'h02, 8'h00);
    st(4'h1, 4'h0);
    rc(8'h03, 8'h30);
    st(4'h1, 4'h1);
    rc(8'h03, 8'h01);
    pls(2, 0);
    rc(8'h07, 8'h30);
    pls(0, 0);
    rc(8'h04, 8'h00);
    pls(0, 1);
    rc(8'h05, 8'h03);
    cls_primary <= 4'h1;
    pls(1, 1);
    pls(1, 0);
    rc(8'h05, 8'h10);
    $display("pair test done");
    u_pcef_host_model.wr(PCEF_OFF_PAIRCFG, 8'h05);
    u_pcef_host_model.wr(PCEF_OFF_CTRL, 8'h08);
    pls(1, 0);
    rc(8'h04, 8'h00);
    pls(1, 1);
    rc(8'h05, 8'h30);
    st(4'h0, 4'h3);
    rc(8'h03, 8'h12);
    pwr_req <= 4'h1;
    pls(0, 1);
    rc(8'h05, 8'h02);
    $display("dual test done");
    print_verdict;
  end
endmodule
